// [logic/ditd_pkg.sv]
package ditd_pkg;

  localparam int unsigned CLK_FREQ_HZ      = 10_000_000;
  localparam int unsigned FILT_STEP_US     = 500;
  localparam int unsigned FILT_STEP_CYCLES = (CLK_FREQ_HZ / 1_000_000) * FILT_STEP_US;
  localparam int unsigned LOSS_TICK_MS     = 100;
  localparam int unsigned LOSS_TICK_CYCLES = (CLK_FREQ_HZ / 1000) * LOSS_TICK_MS;

  localparam logic [4:0] FN_SPEED_L    = 5'h00;
  localparam logic [4:0] FN_SPEED_M    = 5'h01;
  localparam logic [4:0] FN_SPEED_H    = 5'h02;
  localparam logic [4:0] FN_RAMP_L     = 5'h03;
  localparam logic [4:0] FN_RAMP_M     = 5'h04;
  localparam logic [4:0] FN_RAMP_H     = 5'h05;
  localparam logic [4:0] FN_DC_INJECTION_BRAKE   = 5'h06;
  localparam logic [4:0] FN_ALT_PARAM  = 5'h07;
  localparam logic [4:0] FN_V_SWITCH   = 5'h09;
  localparam logic [4:0] FN_UP         = 5'h0A;
  localparam logic [4:0] FN_DOWN       = 5'h0B;
  localparam logic [4:0] FN_THREE_WIRE = 5'h0C;
  localparam logic [4:0] FN_TRIP_NO    = 5'h0D;
  localparam logic [4:0] FN_TRIP_NC    = 5'h0E;
  localparam logic [4:0] FN_OPEN_LOOP  = 5'h10;
  localparam logic [4:0] FN_HOLD       = 5'h12;
  localparam logic [4:0] FN_RAMP_OFF   = 5'h13;

  localparam logic [1:0] LOSS_CRIT_NONE  = 2'h0;
  localparam logic [1:0] LOSS_CRIT_HALF  = 2'h1;
  localparam logic [1:0] LOSS_CRIT_BELOW = 2'h2;

  localparam logic [1:0] LOSS_ACT_NONE  = 2'h0;
  localparam logic [1:0] LOSS_ACT_COAST = 2'h1;
  localparam logic [1:0] LOSS_ACT_STOP  = 2'h2;

  localparam logic [2:0] SRC_KEYPAD_1 = 3'h0;
  localparam logic [2:0] SRC_KEYPAD_2 = 3'h1;
  localparam logic [2:0] SRC_VOLTAGE  = 3'h2;
  localparam logic [2:0] SRC_CURRENT  = 3'h3;
  localparam logic [2:0] SRC_SUMMED   = 3'h4;

  localparam logic [7:0] FILT_RESET = 8'h00;

  typedef enum logic [2:0] {
    LOSS_IDLE    = 3'b001,
    LOSS_WAIT    = 3'b010,
    LOSS_DECLARE = 3'b100
  } ditd_loss_type;

endpackage : ditd_pkg

// [logic/ditd_filter_if.sv]
`timescale 1ns/100ps
interface ditd_filter_if;
  logic       step_en;
  logic [7:0] filt_const;
  logic [7:0] raw;
  logic [7:0] clean;
  modport filt (input step_en, input filt_const, input raw, output clean);
  modport top  (output step_en, output filt_const, output raw, input clean);
endinterface : ditd_filter_if

// [logic/ditd_input_filter.sv]
`timescale 1ns/100ps
module ditd_input_filter
  import ditd_pkg::*;
(
  // Clock and reset.
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // Filter channel.
  ditd_filter_if.filt   fif
);

  logic [7:0] cnt [8];
  logic [7:0] clean;

  assign fif.clean = clean;

  // A new pin level is accepted once it has held through filt_const step pulses, or at the next edge when filt_const is zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clean <= FILT_RESET;
      for (int i = 0; i < 8; i++) begin
        cnt[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (fif.raw[i] == clean[i]) begin
          cnt[i] <= 8'h00;
        end else if (fif.filt_const == 8'h00 || cnt[i] >= fif.filt_const) begin
          clean[i] <= fif.raw[i]; // [RULE23]
          cnt[i]   <= 8'h00;
        end else if (fif.step_en) begin
          cnt[i] <= cnt[i] + 8'h01; // [RULE23]
        end
      end
    end
  end

endmodule : ditd_input_filter

// [logic/ditd_terminal_decoder.sv]
`timescale 1ns/100ps
// Contract
// RULE1: Criterion 0 never checks for loss.
// RULE2: Criterion 1: below half minimum is loss.
// RULE3: Criterion 2: below minimum is loss.
// RULE4: Check only for analog frequency sources.
// RULE5: Action 0 keeps running after loss.
// RULE6: Action 1 cuts output at once.
// RULE7: Action 2 decelerates to stop.
// RULE8: Loss must persist for the timeout.
// RULE9: Timeout and action also cover keypad loss.
// RULE10: Decode each terminal function code.
// RULE11: Speed bits form step frequency index.
// RULE12: Jog overrides every other terminal; run latch, open-loop and trip outputs ignore jog.
// RULE13: Ramp bits form accel/decel index.
// RULE14: DC braking only while stopped and closed.
// RULE15: Alternate terminal selects second parameter set.
// RULE16: Voltage switch takes voltage input reference.
// RULE17: Normally-open trip on latches a fault.
// RULE18: Normally-closed trip off latches a fault.
// RULE19: Open-loop switch accepted only while stopped.
// RULE20: Analog hold freezes frequency until released.
// RULE21: Three-wire latches start from momentary buttons.
// RULE22: Terminal input and output states readable.
// RULE23: Filter time is constant times 0.5 ms.
// RULE24: Loss counter restarts when input recovers.
module ditd_terminal_decoder
  import ditd_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  // Terminal pins, level active high.
  input  wire logic        MULTI_INPUT_A_I,
  input  wire logic        MULTI_INPUT_B_I,
  input  wire logic        MULTI_INPUT_C_I,
  input  wire logic        JOG_I,
  input  wire logic        FWD_RUN_I,
  input  wire logic        REV_RUN_I,
  input  wire logic        FAULT_RESET_I,
  input  wire logic        OUTPUT_BLOCK_I,
  // Configuration.
  input  wire logic [4:0]  FUNC_A_I,
  input  wire logic [4:0]  FUNC_B_I,
  input  wire logic [4:0]  FUNC_C_I,
  input  wire logic [7:0]  FILT_CONST_I,
  input  wire logic [2:0]  FREQ_SOURCE_SELECT_I,
  input  wire logic [1:0]  LOSS_CRIT_I,
  input  wire logic [1:0]  LOSS_ACT_I,
  input  wire logic [7:0]  LOSS_TIMEOUT_I,
  // Analog reference and drive state.
  input  wire logic [11:0] VOLTAGE_ANALOG_IN_I,
  input  wire logic [11:0] CURRENT_ANALOG_IN_I,
  input  wire logic [11:0] VOLTAGE_MIN_I,
  input  wire logic [11:0] CURRENT_MIN_I,
  input  wire logic        KEYPAD_CMD_LOST_I,
  input  wire logic        DRIVE_STOPPED_I,
  input  wire logic [1:0]  OUT_TERMINALS_I,
  // Decoded selections.
  output logic      [2:0]  STEP_INDEX_O,
  output logic      [2:0]  RAMP_INDEX_O,
  output logic             JOG_ACTIVE_O,
  output logic             DC_INJECTION_BRAKE_O,
  output logic             ALTERNATE_PARAM_SET_O,
  output logic             VOLTAGE_SOURCE_SWITCH_O,
  output logic             UP_O,
  output logic             DOWN_O,
  output logic             RUN_LATCH_O,
  output logic             OPEN_LOOP_O,
  output logic             FREQ_HOLD_O,
  output logic             RAMP_DISABLE_O,
  // Trip and loss reaction.
  output logic             EXT_TRIP_O,
  output logic             REF_LOST_O,
  output logic             COAST_STOP_O,
  output logic             DECEL_STOP_O,
  // Status.
  output logic      [7:0]  IN_STATUS_O,
  output logic      [1:0]  OUT_STATUS_O
);

  ditd_filter_if fif ();

  logic [15:0]   filt_div;
  logic [19:0]   tick_div;
  logic          tick;
  logic [7:0]    loss_cnt;
  ditd_loss_type loss_state;
  logic [2:0]    next_step;
  logic [2:0]    next_ramp;
  logic [11:0]   active_in;
  logic [11:0]   active_min;
  logic [11:0]   threshold;
  logic          analog_src;
  logic          below;
  logic          loss_cond;
  logic          ta;
  logic          tb;
  logic          tc;
  logic          jog;
  logic          settled;

  // A pin whose code matches the function, or zero when no pin carries it.
  function automatic logic fn_on(input logic [4:0] code);
    return (FUNC_A_I == code && ta) || (FUNC_B_I == code && tb) || (FUNC_C_I == code && tc);
  endfunction : fn_on

  function automatic logic fn_any(input logic [4:0] code);
    return FUNC_A_I == code || FUNC_B_I == code || FUNC_C_I == code;
  endfunction : fn_any

  assign fif.step_en    = (filt_div == 16'(FILT_STEP_CYCLES - 1));
  assign fif.filt_const = FILT_CONST_I;
  assign fif.raw        = {OUTPUT_BLOCK_I, FAULT_RESET_I, REV_RUN_I, FWD_RUN_I,
                           MULTI_INPUT_C_I, MULTI_INPUT_B_I, MULTI_INPUT_A_I, JOG_I};

  ditd_input_filter u_filter (
    .clk_i (CLOCK_I),
    .rst_i (SYS_RST_I),
    .fif   (fif.filt)
  );

  assign jog = fif.clean[0];
  assign ta  = fif.clean[1];
  assign tb  = fif.clean[2];
  assign tc  = fif.clean[3];

  // A closed trip-B contact reads open until the filter first agrees with the pins after reset.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      settled <= 1'b0;
    end else if (fif.clean == fif.raw) begin
      settled <= 1'b1;
    end
  end

  // One shared step divider feeds every channel, so a response can come up to one step early.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      filt_div <= 16'h0000;
    end else if (fif.step_en) begin
      filt_div <= 16'h0000;
    end else begin
      filt_div <= filt_div + 16'h0001; // [RULE23]
    end
  end

  // The timeout counts in 100 ms ticks so an 8-bit setting covers 25 seconds.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      tick_div <= 20'h00000;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_div == 20'(LOSS_TICK_CYCLES - 1));
      if (tick_div == 20'(LOSS_TICK_CYCLES - 1)) begin
        tick_div <= 20'h00000;
      end else begin
        tick_div <= tick_div + 20'h00001;
      end
    end
  end

  always_comb begin
    next_step = {fn_on(FN_SPEED_H), fn_on(FN_SPEED_M), fn_on(FN_SPEED_L)}; // [RULE10] [RULE11]
    next_ramp = {fn_on(FN_RAMP_H), fn_on(FN_RAMP_M), fn_on(FN_RAMP_L)}; // [RULE10] [RULE13]
    if (jog) begin
      next_step = 3'h0; // [RULE12]
      next_ramp = 3'h0; // [RULE12]
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      STEP_INDEX_O            <= 3'h0;
      RAMP_INDEX_O            <= 3'h0;
      JOG_ACTIVE_O            <= 1'b0;
      DC_INJECTION_BRAKE_O    <= 1'b0;
      ALTERNATE_PARAM_SET_O   <= 1'b0;
      VOLTAGE_SOURCE_SWITCH_O <= 1'b0;
      UP_O                    <= 1'b0;
      DOWN_O                  <= 1'b0;
      FREQ_HOLD_O             <= 1'b0;
      RAMP_DISABLE_O          <= 1'b0;
    end else begin
      STEP_INDEX_O            <= next_step;
      RAMP_INDEX_O            <= next_ramp;
      JOG_ACTIVE_O            <= jog; // [RULE12]
      DC_INJECTION_BRAKE_O    <= !jog && fn_on(FN_DC_INJECTION_BRAKE) && DRIVE_STOPPED_I; // [RULE14]
      ALTERNATE_PARAM_SET_O   <= !jog && fn_on(FN_ALT_PARAM); // [RULE15]
      VOLTAGE_SOURCE_SWITCH_O <= !jog && fn_on(FN_V_SWITCH); // [RULE16]
      UP_O                    <= !jog && fn_on(FN_UP); // [RULE10]
      DOWN_O                  <= !jog && fn_on(FN_DOWN); // [RULE10]
      FREQ_HOLD_O             <= !jog && fn_on(FN_HOLD) && analog_src; // [RULE20]
      RAMP_DISABLE_O          <= !jog && fn_on(FN_RAMP_OFF); // [RULE10]
    end
  end

  // Three-wire: forward starts and latches, the stop button opens the latch.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RUN_LATCH_O <= 1'b0;
    end else if (!fn_any(FN_THREE_WIRE)) begin
      RUN_LATCH_O <= fif.clean[4];
    end else if (!fn_on(FN_THREE_WIRE)) begin
      RUN_LATCH_O <= 1'b0; // [RULE21]
    end else if (fif.clean[4]) begin
      RUN_LATCH_O <= 1'b1; // [RULE21]
    end
  end

  // The mode only changes at standstill to avoid a bump in a running loop.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      OPEN_LOOP_O <= 1'b0;
    end else if (DRIVE_STOPPED_I) begin
      OPEN_LOOP_O <= fn_on(FN_OPEN_LOOP); // [RULE19]
    end
  end

  // Trips stay latched until the filtered reset terminal is seen.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      EXT_TRIP_O <= 1'b0;
    end else if (fn_on(FN_TRIP_NO)) begin
      EXT_TRIP_O <= 1'b1; // [RULE17]
    end else if (settled && ((FUNC_A_I == FN_TRIP_NC && !ta) ||
                 (FUNC_B_I == FN_TRIP_NC && !tb) || (FUNC_C_I == FN_TRIP_NC && !tc))) begin
      EXT_TRIP_O <= 1'b1; // [RULE18]
    end else if (fif.clean[6]) begin
      EXT_TRIP_O <= 1'b0;
    end
  end

  always_comb begin
    analog_src = (FREQ_SOURCE_SELECT_I == SRC_VOLTAGE) || (FREQ_SOURCE_SELECT_I == SRC_CURRENT) ||
                 (FREQ_SOURCE_SELECT_I == SRC_SUMMED); // [RULE4]
    active_in  = (FREQ_SOURCE_SELECT_I == SRC_CURRENT) ? CURRENT_ANALOG_IN_I : VOLTAGE_ANALOG_IN_I;
    active_min = (FREQ_SOURCE_SELECT_I == SRC_CURRENT) ? CURRENT_MIN_I : VOLTAGE_MIN_I;
    threshold  = (LOSS_CRIT_I == LOSS_CRIT_HALF) ? {1'b0, active_min[11:1]} : active_min; // [RULE2]
    below      = active_in < threshold; // [RULE3]
    if (FREQ_SOURCE_SELECT_I == SRC_SUMMED) begin
      below = (VOLTAGE_ANALOG_IN_I < ((LOSS_CRIT_I == LOSS_CRIT_HALF) ?
               {1'b0, VOLTAGE_MIN_I[11:1]} : VOLTAGE_MIN_I)) ||
              (CURRENT_ANALOG_IN_I < ((LOSS_CRIT_I == LOSS_CRIT_HALF) ?
               {1'b0, CURRENT_MIN_I[11:1]} : CURRENT_MIN_I));
    end
    loss_cond = 1'b0;
    if (analog_src && LOSS_CRIT_I != LOSS_CRIT_NONE && LOSS_CRIT_I != 2'h3) begin // [RULE1]
      loss_cond = below;
    end else if (FREQ_SOURCE_SELECT_I == SRC_KEYPAD_1 || FREQ_SOURCE_SELECT_I == SRC_KEYPAD_2) begin
      loss_cond = KEYPAD_CMD_LOST_I; // [RULE9]
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      loss_state <= LOSS_IDLE;
      loss_cnt   <= 8'h00;
    end else begin
      case (loss_state)
        LOSS_IDLE: begin
          loss_cnt <= 8'h00;
          if (loss_cond) begin
            loss_state <= LOSS_WAIT;
          end
        end
        LOSS_WAIT: begin
          if (!loss_cond) begin
            loss_state <= LOSS_IDLE; // [RULE24]
            loss_cnt   <= 8'h00; // [RULE24]
          end else if (loss_cnt >= LOSS_TIMEOUT_I) begin
            loss_state <= LOSS_DECLARE; // [RULE8]
          end else if (tick) begin
            loss_cnt <= loss_cnt + 8'h01; // [RULE8]
          end
        end
        LOSS_DECLARE: begin
          if (!loss_cond) begin
            loss_state <= LOSS_IDLE;
          end
        end
        default: begin
          loss_state <= LOSS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REF_LOST_O   <= 1'b0;
      COAST_STOP_O <= 1'b0;
      DECEL_STOP_O <= 1'b0;
    end else begin
      REF_LOST_O   <= (loss_state == LOSS_DECLARE); // [RULE5]
      COAST_STOP_O <= (loss_state == LOSS_DECLARE) && LOSS_ACT_I == LOSS_ACT_COAST; // [RULE6]
      DECEL_STOP_O <= (loss_state == LOSS_DECLARE) && LOSS_ACT_I == LOSS_ACT_STOP; // [RULE7]
    end
  end

  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      IN_STATUS_O  <= 8'h00;
      OUT_STATUS_O <= 2'h0;
    end else begin
      IN_STATUS_O  <= fif.clean; // [RULE22]
      OUT_STATUS_O <= OUT_TERMINALS_I; // [RULE22]
    end
  end

endmodule : ditd_terminal_decoder

// [test/ditd_field_model.sv]
`timescale 1ns/100ps
module ditd_field_model (
  // Clock.
  input  wire logic       clk_i,
  // Contact positions wanted by the operator.
  input  wire logic [7:0] sw_i,
  // Terminal pins, {blk,rst,rev,fwd,C,B,A,jog}.
  output logic      [7:0] pin_o
);
  // Contacts move only on the falling edge, so the decoder never sees a pin change on its edge.
  // The bench closes the alternate-set contact only with the drive stopped, and closes the brake contact once with it running.
  always @(negedge clk_i) pin_o <= sw_i;
endmodule : ditd_field_model

// [test/ditd_decoder_asserts.sv]
`timescale 1ns/100ps
module ditd_decoder_asserts
  import ditd_pkg::*;
(
  // Clock and reset.
  input wire logic        CLOCK_I,
  input wire logic        SYS_RST_I,
  // Watched inputs.
  input wire logic        JOG_I,
  input wire logic        FAULT_RESET_I,
  input wire logic [7:0]  FILT_CONST_I,
  input wire logic [2:0]  FREQ_SOURCE_SELECT_I,
  input wire logic [1:0]  LOSS_CRIT_I,
  input wire logic [1:0]  LOSS_ACT_I,
  input wire logic [7:0]  LOSS_TIMEOUT_I,
  input wire logic [11:0] VOLTAGE_ANALOG_IN_I,
  input wire logic [11:0] CURRENT_ANALOG_IN_I,
  input wire logic [11:0] VOLTAGE_MIN_I,
  input wire logic [11:0] CURRENT_MIN_I,
  input wire logic        KEYPAD_CMD_LOST_I,
  input wire logic        DRIVE_STOPPED_I,
  input wire logic [1:0]  OUT_TERMINALS_I,
  // Watched outputs.
  input wire logic [2:0]  STEP_INDEX_O,
  input wire logic [2:0]  RAMP_INDEX_O,
  input wire logic        DC_INJECTION_BRAKE_O,
  input wire logic        OPEN_LOOP_O,
  input wire logic        EXT_TRIP_O,
  input wire logic        REF_LOST_O,
  input wire logic        COAST_STOP_O,
  input wire logic        DECEL_STOP_O,
  input wire logic [1:0]  OUT_STATUS_O
);
  logic [11:0] tv;
  logic [11:0] tc;
  logic        cnd;
  logic        sv;
  logic        sc;
  assign tv = (LOSS_CRIT_I == LOSS_CRIT_HALF) ? VOLTAGE_MIN_I >> 1 : VOLTAGE_MIN_I;
  assign tc = (LOSS_CRIT_I == LOSS_CRIT_HALF) ? CURRENT_MIN_I >> 1 : CURRENT_MIN_I;
  assign sv = FREQ_SOURCE_SELECT_I == SRC_VOLTAGE || FREQ_SOURCE_SELECT_I == SRC_SUMMED;
  assign sc = FREQ_SOURCE_SELECT_I == SRC_CURRENT || FREQ_SOURCE_SELECT_I == SRC_SUMMED;
  assign cnd = (LOSS_CRIT_I == LOSS_CRIT_HALF || LOSS_CRIT_I == LOSS_CRIT_BELOW) &&
               ((sv && VOLTAGE_ANALOG_IN_I < tv) || (sc && CURRENT_ANALOG_IN_I < tc));
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);
  sequence s_loss_now;
    (cnd && LOSS_TIMEOUT_I == 8'h00) [*4];
  endsequence
  sequence s_no_fault_reset;
    (!FAULT_RESET_I && FILT_CONST_I == 8'h00) [*4];
  endsequence
  property p_loss_rise;
    s_loss_now |=> REF_LOST_O;
  endproperty
  property p_no_loss;
    !(cnd || KEYPAD_CMD_LOST_I) [*3] |-> !REF_LOST_O;
  endproperty
  property p_action;
    REF_LOST_O && $stable(LOSS_ACT_I) |-> COAST_STOP_O == (LOSS_ACT_I == LOSS_ACT_COAST) &&
      DECEL_STOP_O == (LOSS_ACT_I == LOSS_ACT_STOP);
  endproperty
  property p_trip_hold;
    s_no_fault_reset ##0 EXT_TRIP_O |=> EXT_TRIP_O;
  endproperty
  property p_jog;
    (JOG_I && FILT_CONST_I == 8'h00) [*4] |=> STEP_INDEX_O == 3'h0 && RAMP_INDEX_O == 3'h0;
  endproperty
  property p_dc_stop;
    !DRIVE_STOPPED_I [*3] |-> !DC_INJECTION_BRAKE_O;
  endproperty
  property p_open_loop;
    !DRIVE_STOPPED_I [*2] |-> $stable(OPEN_LOOP_O);
  endproperty
  property p_out_status;
    !$past(SYS_RST_I) && !$past(SYS_RST_I, 2) |-> OUT_STATUS_O == $past(OUT_TERMINALS_I);
  endproperty
  a_loss_rise: assert property (p_loss_rise) else $error("Loss not declared");
  a_no_loss: assert property (p_no_loss) else $error("Loss without cause");
  a_action: assert property (p_action) else $error("Wrong loss action");
  a_trip_hold: assert property (p_trip_hold) else $error("Trip dropped");
  a_jog: assert property (p_jog) else $error("Jog did not clear indices");
  a_dc_stop: assert property (p_dc_stop) else $error("Brake while running");
  a_open_loop: assert property (p_open_loop) else $error("Mode changed while running");
  a_out_status: assert property (p_out_status) else $error("Output status wrong");
endmodule : ditd_decoder_asserts

bind ditd_terminal_decoder ditd_decoder_asserts ditd_decoder_asserts_i (
  .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .JOG_I(JOG_I), .FAULT_RESET_I(FAULT_RESET_I),
  .FILT_CONST_I(FILT_CONST_I), .FREQ_SOURCE_SELECT_I(FREQ_SOURCE_SELECT_I),
  .LOSS_CRIT_I(LOSS_CRIT_I), .LOSS_ACT_I(LOSS_ACT_I), .LOSS_TIMEOUT_I(LOSS_TIMEOUT_I),
  .VOLTAGE_ANALOG_IN_I(VOLTAGE_ANALOG_IN_I), .CURRENT_ANALOG_IN_I(CURRENT_ANALOG_IN_I),
  .VOLTAGE_MIN_I(VOLTAGE_MIN_I), .CURRENT_MIN_I(CURRENT_MIN_I),
  .KEYPAD_CMD_LOST_I(KEYPAD_CMD_LOST_I), .DRIVE_STOPPED_I(DRIVE_STOPPED_I),
  .OUT_TERMINALS_I(OUT_TERMINALS_I), .STEP_INDEX_O(STEP_INDEX_O), .RAMP_INDEX_O(RAMP_INDEX_O),
  .DC_INJECTION_BRAKE_O(DC_INJECTION_BRAKE_O), .OPEN_LOOP_O(OPEN_LOOP_O),
  .EXT_TRIP_O(EXT_TRIP_O), .REF_LOST_O(REF_LOST_O), .COAST_STOP_O(COAST_STOP_O),
  .DECEL_STOP_O(DECEL_STOP_O), .OUT_STATUS_O(OUT_STATUS_O));

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import ditd_pkg::*;
  localparam logic [4:0] codes [8] = '{FN_DC_INJECTION_BRAKE, FN_ALT_PARAM, FN_V_SWITCH, FN_UP,
                                       FN_DOWN, FN_HOLD, FN_RAMP_OFF, 5'h08};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sw = 8'h00;
  logic [7:0]  pin;
  logic [7:0]  ist;
  logic [7:0]  fcon = 8'h00;
  logic [7:0]  tmo = 8'h00;
  logic [4:0]  fa = 5'h1F;
  logic [4:0]  fb = 5'h1F;
  logic [4:0]  fc = 5'h1F;
  logic [2:0]  src = SRC_KEYPAD_1;
  logic [2:0]  si;
  logic [2:0]  ri;
  logic [1:0]  crit = 2'h0;
  logic [1:0]  act = 2'h0;
  logic [1:0]  ot = 2'h0;
  logic [1:0]  ost;
  logic [11:0] va = 12'hFFF;
  logic [11:0] ca = 12'hFFF;
  logic        kl = 1'b0;
  logic        stp = 1'b1;
  logic        jo, dc, alt, vsw, up, dn, run, ol, hold, rdis, trip, lost, coast, decel;
  int          error_cnt = 0;
  int          checks_done = 0;
  wire [6:0]   fo = {dc, alt, vsw, up, dn, hold, rdis};

  ditd_field_model ditd_field_model_i (.clk_i(clk), .sw_i(sw), .pin_o(pin));

  ditd_terminal_decoder ditd_terminal_decoder_i (
    .CLOCK_I(clk), .SYS_RST_I(rst), .JOG_I(pin[0]), .MULTI_INPUT_A_I(pin[1]),
    .MULTI_INPUT_B_I(pin[2]), .MULTI_INPUT_C_I(pin[3]), .FWD_RUN_I(pin[4]), .REV_RUN_I(pin[5]),
    .FAULT_RESET_I(pin[6]), .OUTPUT_BLOCK_I(pin[7]), .FUNC_A_I(fa), .FUNC_B_I(fb),
    .FUNC_C_I(fc), .FILT_CONST_I(fcon), .FREQ_SOURCE_SELECT_I(src), .LOSS_CRIT_I(crit),
    .LOSS_ACT_I(act), .LOSS_TIMEOUT_I(tmo), .VOLTAGE_ANALOG_IN_I(va), .CURRENT_ANALOG_IN_I(ca),
    .VOLTAGE_MIN_I(12'h100), .CURRENT_MIN_I(12'h100), .KEYPAD_CMD_LOST_I(kl),
    .DRIVE_STOPPED_I(stp), .OUT_TERMINALS_I(ot), .STEP_INDEX_O(si), .RAMP_INDEX_O(ri),
    .JOG_ACTIVE_O(jo), .DC_INJECTION_BRAKE_O(dc), .ALTERNATE_PARAM_SET_O(alt),
    .VOLTAGE_SOURCE_SWITCH_O(vsw), .UP_O(up), .DOWN_O(dn), .RUN_LATCH_O(run),
    .OPEN_LOOP_O(ol), .FREQ_HOLD_O(hold), .RAMP_DISABLE_O(rdis), .EXT_TRIP_O(trip),
    .REF_LOST_O(lost), .COAST_STOP_O(coast), .DECEL_STOP_O(decel), .IN_STATUS_O(ist),
    .OUT_STATUS_O(ost));

  initial forever #50 clk = ~clk;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holding long enough covers filter, decode and loss walk with a zero constant.
  task automatic go(input logic [7:0] v, input int n);
    @(negedge clk);
    sw <= v;
    repeat (n) @(negedge clk);
  endtask : go

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    int n;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 2; k++) begin
      ot = 2'(k + 1);
      go(k ? 8'hAA : 8'h55, 6);
      chk(12'(ist), k ? 12'h0AA : 12'h055);
      chk(12'(ost), 12'(ot));
    end
    $display("Test status done");
    for (int f = 0; f < 2; f++) begin
      {fa, fb, fc} = f ? {FN_RAMP_L, FN_RAMP_M, FN_RAMP_H} : {FN_SPEED_L, FN_SPEED_M, FN_SPEED_H};
      for (int v = 0; v < 8; v++) begin
        go({4'h0, 3'(v), 1'b0}, 6);
        chk(12'(f ? ri : si), 12'(v));
      end
      go(8'h0F, 6);
      chk(12'({si, ri}), 12'h000);
      chk(12'(jo), 12'h001);
    end
    $display("Test index done");
    {fb, fc} = 10'h3FF;
    src = SRC_VOLTAGE;
    for (int k = 0; k < 8; k++) begin
      fa = codes[k];
      go(8'h02, 6);
      chk(12'(fo), k < 7 ? 12'h040 >> k : 12'h000);
      go(8'h00, 6);
    end
    stp = 1'b0;
    fa = FN_DC_INJECTION_BRAKE;
    go(8'h02, 6);
    chk(12'(dc), 12'h000);
    fa = FN_OPEN_LOOP;
    go(8'h02, 6);
    chk(12'(ol), 12'h000);
    stp = 1'b1;
    go(8'h02, 6);
    chk(12'(ol), 12'h001);
    $display("Test functions done");
    for (int k = 0; k < 2; k++) begin
      fa = k ? FN_TRIP_NC : FN_TRIP_NO;
      go(k ? 8'h00 : 8'h02, 6);
      go(k ? 8'h02 : 8'h00, 6);
      chk(12'(trip), 12'h001);
      go(k ? 8'h42 : 8'h40, 6);
      chk(12'(trip), 12'h000);
    end
    fa = 5'h1F;
    fb = FN_THREE_WIRE;
    go(8'h14, 6);
    go(8'h04, 6);
    chk(12'(run), 12'h001);
    go(8'h00, 6);
    chk(12'(run), 12'h000);
    $display("Test trip and three-wire done");
    for (int k = 0; k < 3; k++) begin
      crit = 2'(k);
      va = 12'h0C0;
      go(8'h00, 8);
      chk(12'(lost), 12'(k == 2));
      va = 12'h040;
      go(8'h00, 8);
      chk(12'(lost), 12'(k != 0));
      va = 12'hFFF;
      go(8'h00, 8);
    end
    for (int k = 0; k < 3; k++) begin
      act = 2'(k);
      va = 12'h040;
      go(8'h00, 8);
      chk(12'({lost, coast, decel}), 12'({1'b1, k == 1, k == 2}));
      va = 12'hFFF;
      go(8'h00, 8);
    end
    ca = 12'h040;
    for (int k = 0; k < 5; k++) begin
      src = 3'(k);
      go(8'h00, 8);
      chk(12'(lost), 12'(k == 3 || k == 4));
    end
    ca = 12'hFFF;
    src = SRC_KEYPAD_2;
    kl = 1'b1;
    go(8'h00, 8);
    chk(12'(lost), 12'h001);
    kl = 1'b0;
    go(8'h00, 8);
    chk(12'(lost), 12'h000);
    src = SRC_VOLTAGE;
    tmo = 8'h01;
    va = 12'h040;
    go(8'h00, 200);
    chk(12'(lost), 12'h000);
    va = 12'hFFF;
    tmo = 8'h00;
    $display("Test loss done");
    fcon = 8'h02;
    go(8'h01, 4);
    chk(12'(ist[0]), 12'h000);
    for (n = 0; n < 11000 && ist[0] !== 1'b1; n++) @(negedge clk);
    chk(12'(n >= 4996 && n < 10010), 12'h001);
    $display("Test filter done");
    end_sim();
  end
endmodule : tb_top
